// File: cbt_consts.svh
// Offsets, field positions, reset values and timing counts of the CAN bit-timing segment block.
`ifndef CBT_CONSTS_SVH
`define CBT_CONSTS_SVH
`define CBT_AW 5
`define CBT_OFF_PRESC 5'h00
`define CBT_OFF_SEG_A 5'h04
`define CBT_OFF_P2W 5'h08
`define CBT_OFF_CTRL 5'h0C
`define CBT_OFF_STAT 5'h10
`define CBT_P2MODE_BIT 7
`define CBT_TRIPLE_BIT 6
`define CBT_P1_MSB 5
`define CBT_P1_LSB 3
`define CBT_PROP_MSB 2
`define CBT_PROP_LSB 0
`define CBT_WAKEF_BIT 6
`define CBT_P2_MSB 2
`define CBT_P2_LSB 0
`define CBT_P2W_MASK 8'h47
`define CBT_RST_PRESC 6'h00
`define CBT_RST_SEG 8'h00
`define CBT_RST_CFGMODE 1'b1
`define CBT_IPT_TQ 4'h2
`define CBT_CLK_NS 20
`define CBT_WAKE_FILT_NS 200
`define CBT_WAKE_FILT_CYC ((`CBT_WAKE_FILT_NS + `CBT_CLK_NS - 1) / `CBT_CLK_NS)
`define CBT_RESP_OKAY 2'h0
`define CBT_RESP_SLVERR 2'h2
`endif

// File: cbt_pkg.sv
// Types shared by the CAN bit-timing segment block.
package cbt_pkg;
  // One-hot segment states of the nominal bit.
  typedef enum logic [3:0] {
    CBT_SYNC = 4'h1,
    CBT_PROP = 4'h2,
    CBT_PH1 = 4'h4,
    CBT_PH2 = 4'h8
  } cbt_state_t;

  // Bit-timing settings as software programmed them.
  typedef struct packed {
    logic [5:0] quantum_prescaler;
    logic phase2_select_mode;
    logic triple_sample_select;
    logic [2:0] phase1_length;
    logic [2:0] propagation_length;
    logic wake_line_filter;
    logic [2:0] phase2_length;
  } cbt_cfg_t;
endpackage

// File: cbt_top.sv
// CAN bit-timing segment block with its AXI4-Lite register slave.
//
// Function
// - Phase 2 from field, or max(phase1, INFO_PROCESSING_TIME).
// - Triple-sample bit selects majority of three samples.
// - Propagation segment lasts field plus one quanta.
// - Wake filter bit filters line before wake.
// - Phase 2 field plus one, ignored in auto.
// - Timing settings writable only in configuration mode.
// - Quantum is 2*(prescaler+1) oscillator clocks.
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "cbt_consts.svh"
module cbt_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [`CBT_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CBT_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic can_rx,
  output logic tq_tick,
  output logic sample_point,
  output logic sampled_bit,
  output logic wake_event,
  output cbt_pkg::cbt_state_t bit_state,
  output cbt_pkg::cbt_cfg_t bt_cfg
);
  // Register decode, shared by the read and the write path; 3'h7 marks an unmapped word.
  function automatic logic [2:0] reg_sel(input logic [`CBT_AW-1:0] a);
    unique case (a)
      `CBT_OFF_PRESC: reg_sel = 3'h0;
      `CBT_OFF_SEG_A: reg_sel = 3'h1;
      `CBT_OFF_P2W: reg_sel = 3'h2;
      `CBT_OFF_CTRL: reg_sel = 3'h3;
      `CBT_OFF_STAT: reg_sel = 3'h4;
      default: reg_sel = 3'h7;
    endcase
  endfunction

  // Bus and register state.
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [`CBT_AW-1:0] aw_addr_r, aw_addr_nxt;
  logic [7:0] w_byte_r, w_byte_nxt; // Only the low byte carries settings.
  logic w_lane_r, w_lane_nxt; // Byte-lane 0 strobe of the held write.
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [5:0] presc_r, presc_nxt;
  logic [7:0] seg_a_r, seg_a_nxt, p2w_r, p2w_nxt;
  logic cfg_mode_r, cfg_mode_nxt; // High while the controller is in configuration mode.
  logic wr_fire;
  logic [31:0] stat_word;
  logic [3:0] ph2_len;

  // Timing state.
  cbt_pkg::cbt_state_t st_r, st_nxt;
  logic [6:0] div_r, div_nxt;
  logic [3:0] seg_cnt_r, seg_cnt_nxt;
  logic [1:0] smp_hist_r, smp_hist_nxt;
  logic sbit_r, sbit_nxt, sp_r, sp_nxt;
  logic tick;
  logic [3:0] cur_len;

  // Receive line and wake state.
  logic rx_m1_r, rx_m2_r, rx_m3_r, rx_clean_r, rx_clean_nxt;
  logic [4:0] filt_r, filt_nxt;
  logic wake_low_r, wake_low_nxt, wake_ev_r, wake_ev_nxt;

  assign s_axi_awready = !aw_hold_r;
  assign s_axi_wready = !w_hold_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;

  // Settings fan out as one struct to the rest of the controller.
  assign bt_cfg = '{presc_r, seg_a_r[`CBT_P2MODE_BIT], seg_a_r[`CBT_TRIPLE_BIT],
                    seg_a_r[`CBT_P1_MSB:`CBT_P1_LSB], seg_a_r[`CBT_PROP_MSB:`CBT_PROP_LSB],
                    p2w_r[`CBT_WAKEF_BIT], p2w_r[`CBT_P2_MSB:`CBT_P2_LSB]};

  // Effective phase 2: the free field, or the greater of phase 1 and the processing time.
  always_comb
  begin
    if (bt_cfg.phase2_select_mode)
      ph2_len = {1'b0, bt_cfg.phase2_length} + 4'h1;
    else if ({1'b0, bt_cfg.phase1_length} + 4'h1 > `CBT_IPT_TQ)
      ph2_len = {1'b0, bt_cfg.phase1_length} + 4'h1;
    else
      ph2_len = `CBT_IPT_TQ;
  end

  assign stat_word = {20'h0, ph2_len, 2'h0, rx_clean_r, sbit_r, st_r};

  // Bus next state: address and data are held independently, then written together.
  always_comb
  begin
    aw_hold_nxt = aw_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_hold_nxt = w_hold_r;
    w_byte_nxt = w_byte_r;
    w_lane_nxt = w_lane_r;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    presc_nxt = presc_r;
    seg_a_nxt = seg_a_r;
    p2w_nxt = p2w_r;
    cfg_mode_nxt = cfg_mode_r;
    if (s_axi_awvalid && !aw_hold_r)
    begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_r)
    begin
      w_hold_nxt = 1'b1;
      w_byte_nxt = s_axi_wdata[7:0];
      w_lane_nxt = s_axi_wstrb[0];
    end
    if (wr_fire)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `CBT_RESP_OKAY;
      // Timing writes outside configuration mode are answered but dropped, so a live bit is never torn.
      unique case (reg_sel(aw_addr_r))
        3'h0: if (w_lane_r && cfg_mode_r) presc_nxt = w_byte_r[5:0];
        3'h1: if (w_lane_r && cfg_mode_r) seg_a_nxt = w_byte_r;
        3'h2: if (w_lane_r && cfg_mode_r) p2w_nxt = w_byte_r & `CBT_P2W_MASK;
        3'h3: if (w_lane_r) cfg_mode_nxt = w_byte_r[0];
        3'h4: ; // Status is read-only; the write is ignored.
        default: bresp_nxt = `CBT_RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && !rvalid_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `CBT_RESP_OKAY;
      unique case (reg_sel(s_axi_araddr))
        3'h0: rdata_nxt = {26'h0, presc_r};
        3'h1: rdata_nxt = {24'h0, seg_a_r};
        3'h2: rdata_nxt = {24'h0, p2w_r};
        3'h3: rdata_nxt = {31'h0, cfg_mode_r};
        3'h4: rdata_nxt = stat_word;
        default:
        begin
          rdata_nxt = 32'h0;
          rresp_nxt = `CBT_RESP_SLVERR;
        end
      endcase
    end
  end

  // Bus registers.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 5'h00;
      w_hold_r <= 1'b0;
      w_byte_r <= 8'h00;
      w_lane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rresp_r <= 2'h0;
      rdata_r <= 32'h0;
      presc_r <= `CBT_RST_PRESC;
      seg_a_r <= `CBT_RST_SEG;
      p2w_r <= `CBT_RST_SEG;
      cfg_mode_r <= `CBT_RST_CFGMODE;
    end
    else
    begin
      aw_hold_r <= aw_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_hold_r <= w_hold_nxt;
      w_byte_r <= w_byte_nxt;
      w_lane_r <= w_lane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      presc_r <= presc_nxt;
      seg_a_r <= seg_a_nxt;
      p2w_r <= p2w_nxt;
      cfg_mode_r <= cfg_mode_nxt;
    end
  end

  // Length in quanta of the segment now running.
  always_comb
  begin
    unique case (st_r)
      cbt_pkg::CBT_SYNC: cur_len = 4'h1;
      cbt_pkg::CBT_PROP: cur_len = {1'b0, bt_cfg.propagation_length} + 4'h1;
      cbt_pkg::CBT_PH1: cur_len = {1'b0, bt_cfg.phase1_length} + 4'h1;
      cbt_pkg::CBT_PH2: cur_len = ph2_len;
      default: cur_len = 4'h1;
    endcase
  end

  assign tick = !cfg_mode_r && (div_r == {presc_r, 1'b1});
  assign tq_tick = tick;
  assign bit_state = st_r;
  assign sample_point = sp_r;
  assign sampled_bit = sbit_r;

  // Quantum divider and segment sequencer; both rest in configuration mode.
  always_comb
  begin
    div_nxt = tick || cfg_mode_r ? 7'h00 : div_r + 7'h01;
    st_nxt = st_r;
    seg_cnt_nxt = seg_cnt_r;
    smp_hist_nxt = smp_hist_r;
    sbit_nxt = sbit_r;
    sp_nxt = 1'b0;
    if (cfg_mode_r)
    begin
      st_nxt = cbt_pkg::CBT_SYNC;
      seg_cnt_nxt = 4'h0;
    end
    else if (tick)
    begin
      smp_hist_nxt = {smp_hist_r[0], rx_clean_r};
      if (seg_cnt_r + 4'h1 >= cur_len)
      begin
        seg_cnt_nxt = 4'h0;
        unique case (st_r)
          cbt_pkg::CBT_SYNC: st_nxt = cbt_pkg::CBT_PROP;
          cbt_pkg::CBT_PROP: st_nxt = cbt_pkg::CBT_PH1;
          cbt_pkg::CBT_PH1:
          begin
            st_nxt = cbt_pkg::CBT_PH2;
            sp_nxt = 1'b1;
            // Majority of the two earlier quanta and this one trades a quantum of lag for noise immunity.
            if (bt_cfg.triple_sample_select)
              sbit_nxt = (smp_hist_r[1] & smp_hist_r[0]) | (smp_hist_r[1] & rx_clean_r)
                         | (smp_hist_r[0] & rx_clean_r);
            else
              sbit_nxt = rx_clean_r;
          end
          cbt_pkg::CBT_PH2: st_nxt = cbt_pkg::CBT_SYNC;
          default: st_nxt = cbt_pkg::CBT_SYNC;
        endcase
      end
      else
        seg_cnt_nxt = seg_cnt_r + 4'h1;
    end
  end

  // Timing registers.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      div_r <= 7'h00;
      st_r <= cbt_pkg::CBT_SYNC;
      seg_cnt_r <= 4'h0;
      smp_hist_r <= 2'h3;
      sbit_r <= 1'b1;
      sp_r <= 1'b0;
    end
    else
    begin
      div_r <= div_nxt;
      st_r <= st_nxt;
      seg_cnt_r <= seg_cnt_nxt;
      smp_hist_r <= smp_hist_nxt;
      sbit_r <= sbit_nxt;
      sp_r <= sp_nxt;
    end
  end

  // Clean line follows the pin once the second and third stages agree; optional low filter for wake.
  always_comb
  begin
    rx_clean_nxt = (rx_m2_r == rx_m3_r) ? rx_m3_r : rx_clean_r;
    filt_nxt = rx_clean_r ? 5'h00 : (filt_r == 5'(`CBT_WAKE_FILT_CYC) ? filt_r : filt_r + 5'h01);
    if (bt_cfg.wake_line_filter)
      wake_low_nxt = filt_r == 5'(`CBT_WAKE_FILT_CYC);
    else
      wake_low_nxt = !rx_clean_r;
    wake_ev_nxt = wake_low_nxt && !wake_low_r;
  end

  // Line and wake registers; the bus idles recessive, so reset loads ones into the line stages and zeros into the wake state.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rx_m1_r <= 1'b1;
      rx_m2_r <= 1'b1;
      rx_m3_r <= 1'b1;
      rx_clean_r <= 1'b1;
      filt_r <= 5'h00;
      wake_low_r <= 1'b0;
      wake_ev_r <= 1'b0;
    end
    else
    begin
      rx_m1_r <= can_rx;
      rx_m2_r <= rx_m1_r;
      rx_m3_r <= rx_m2_r;
      rx_clean_r <= rx_clean_nxt;
      filt_r <= filt_nxt;
      wake_low_r <= wake_low_nxt;
      wake_ev_r <= wake_ev_nxt;
    end
  end
  assign wake_event = wake_ev_r;

  // Clock count since the previous quantum, read only by the checks below.
  logic [7:0] gap_r;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || cfg_mode_r || tick)
      gap_r <= 8'h01;
    else if (gap_r != 8'hFF)
      gap_r <= gap_r + 8'h01;
  end

  sequence seq_seg_write;
    wr_fire && reg_sel(aw_addr_r) == 3'h1 && w_lane_r;
  endsequence
  sequence seq_leave_ph1;
    tick && st_r == cbt_pkg::CBT_PH1 && st_nxt == cbt_pkg::CBT_PH2;
  endsequence

  a_refused_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    seq_seg_write and !cfg_mode_r |=> $stable(seg_a_r)) else $error("segment write taken outside config mode");
  a_taken_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    seq_seg_write and cfg_mode_r |=> seg_a_r == $past(w_byte_r)) else $error("segment write lost in config mode");
  a_quantum_len: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tick && $past(tick) == 1'b0 && $stable(presc_r) && gap_r != 8'h01 |-> gap_r == 8'(2 * (presc_r + 1)))
    else $error("quantum length wrong");
  a_prop_len: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tick && st_r == cbt_pkg::CBT_PROP && st_nxt == cbt_pkg::CBT_PH1 |-> seg_cnt_r == {1'b0, seg_a_r[2:0]})
    else $error("propagation segment length wrong");
  a_ph1_len: assert property (@(posedge clk_sys) disable iff (sys_rst)
    seq_leave_ph1 |-> seg_cnt_r == {1'b0, seg_a_r[5:3]}) else $error("phase 1 length wrong");
  a_ph2_free: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tick && st_r == cbt_pkg::CBT_PH2 && st_nxt == cbt_pkg::CBT_SYNC && seg_a_r[7] |-> seg_cnt_r == {1'b0, p2w_r[2:0]})
    else $error("free phase 2 length wrong");
  a_ph2_auto: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !seg_a_r[7] |-> ph2_len >= `CBT_IPT_TQ && ph2_len >= {1'b0, seg_a_r[5:3]} + 4'h1) else $error("auto phase 2 short");
  a_single_sample: assert property (@(posedge clk_sys) disable iff (sys_rst)
    seq_leave_ph1 and !seg_a_r[6] |=> sample_point && sampled_bit == $past(rx_clean_r)) else $error("single sample wrong");
  a_triple_agree: assert property (@(posedge clk_sys) disable iff (sys_rst)
    seq_leave_ph1 and seg_a_r[6] && smp_hist_r == 2'h0 |=> sampled_bit == 1'b0) else $error("triple sample majority wrong");
  a_wake_direct: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !p2w_r[6] && $fell(rx_clean_r) && !wake_low_r |=> wake_event) else $error("unfiltered wake missed");
  a_wake_filtered: assert property (@(posedge clk_sys) disable iff (sys_rst)
    p2w_r[6] && $fell(rx_clean_r) |=> !wake_event [*8]) else $error("filtered wake too early");
endmodule

// File: cbt_bus_model.sv
// Behavioural model of the CAN bus line that feeds the receive pin of the bit-timing block.
`timescale 1ns/1ps
module cbt_bus_model (
  input wire logic clk_sys,
  output logic can_rx
);
  // The bus termination pulls the line recessive, so it rests high whenever no node drives it.
  initial can_rx = 1'b1;

  // Drive the line dominant for n clocks, then release it back to recessive.
  // Called just after a rising edge, so the line never moves on the sampling edge.
  task automatic dominant(input int n);
    can_rx <= 1'b0;
    repeat (n) @(posedge clk_sys);
    can_rx <= 1'b1;
  endtask
endmodule

// File: tb.sv
// Self-checking testbench of the bit-timing block, driven over its register bus.
`timescale 1ns/1ps
`include "cbt_consts.svh"
module tb;
  logic clk_sys, sys_rst;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, bresp_q, rresp_q;
  logic can_rx, tq_tick, sample_point, sampled_bit, wake_event;
  cbt_pkg::cbt_state_t bit_state;
  cbt_pkg::cbt_cfg_t bt_cfg;
  int errors, n_tests, wake_n, n, ph1, ph2, bitq;
  // Segment settings tried in turn: free phase 2, derived phase 2, derived with short phase 1.
  logic [7:0] seg_tab [3] = '{8'h91, 8'h11, 8'h41};

  cbt_top dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .can_rx(can_rx), .tq_tick(tq_tick), .sample_point(sample_point),
    .sampled_bit(sampled_bit), .wake_event(wake_event), .bit_state(bit_state), .bt_cfg(bt_cfg));
  cbt_bus_model bus_u (.clk_sys(clk_sys), .can_rx(can_rx));

  // A 50 MHz clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Wake pulses are counted on the falling edge, where the registered output has settled.
  always @(negedge clk_sys)
    if (wake_event === 1'b1)
      wake_n++;

  // Print the verdict and end the run.
  task summarize();
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Compare one value and count it.
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // A wait that ran out is a mismatch and closes the run.
  task hang(input string what);
    errors++;
    $display("wrong value %s expected done seen timeout", what);
    summarize();
  endtask

  // One write; readies are looked at in the low phase, which equals their value at the next edge.
  task wr(input logic [4:0] a, input logic [7:0] d);
    int k;
    logic ar, wr_r, bv;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(negedge clk_sys);
      ar = s_axi_awready;
      wr_r = s_axi_wready;
      bv = s_axi_bvalid;
      bresp_q = s_axi_bresp;
      @(posedge clk_sys);
      if (ar) s_axi_awvalid <= 1'b0;
      if (wr_r) s_axi_wvalid <= 1'b0;
      if (bv) break;
    end
    if (k == 50) hang("write");
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  // One read; the data and response are taken at the edge where rvalid is high.
  task rd(input logic [4:0] a);
    int k;
    logic ar, rv;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(negedge clk_sys);
      ar = s_axi_arready;
      rv = s_axi_rvalid;
      rd_q = s_axi_rdata;
      rresp_q = s_axi_rresp;
      @(posedge clk_sys);
      if (ar) s_axi_arvalid <= 1'b0;
      if (rv) break;
    end
    if (k == 50) hang("read");
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Clocks between two pulses of the quantum tick (sel 0) or of the sample point (sel 1).
  task gap(input bit sel, output int cnt);
    int k;
    logic p;
    cnt = 0;
    for (k = 0; k < 600; k++)
    begin
      @(negedge clk_sys);
      p = sel ? sample_point : tq_tick;
      if (cnt > 0 || (p === 1'b1 && k > 0 && cnt == 0 && sel === 1'bx)) cnt++;
      if (p === 1'b1)
      begin
        if (cnt > 0) break;
        cnt = 1;
      end
    end
    if (k == 600) hang("pulse");
    cnt = cnt - 1;
    @(posedge clk_sys);
  endtask

  initial
  begin
    sys_rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    errors = 0;
    n_tests = 0;
    wake_n = 0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    check("state at rest", bit_state, 32'h00000001);
    rd(`CBT_OFF_PRESC); check("prescaler reset", rd_q, 32'h00000000);
    rd(`CBT_OFF_SEG_A); check("segments reset", rd_q, 32'h00000000);
    rd(`CBT_OFF_P2W); check("phase2 reset", rd_q, 32'h00000000);
    rd(`CBT_OFF_CTRL); check("config mode reset", rd_q, 32'h00000001);
    rd(5'h14); check("unmapped resp", {30'h0, rresp_q}, {30'h0, `CBT_RESP_SLVERR});
    check("unmapped data", rd_q, 32'h00000000);
    wr(`CBT_OFF_P2W, 8'hFF); rd(`CBT_OFF_P2W); check("phase2 mask", rd_q, 32'h00000047);
    // Each setting: prescaler i, then quantum length and bit length follow from the fields.
    for (int i = 0; i < 3; i++)
    begin
      wr(`CBT_OFF_CTRL, 8'h01);
      wr(`CBT_OFF_PRESC, i[7:0]);
      wr(`CBT_OFF_SEG_A, seg_tab[i]);
      wr(`CBT_OFF_P2W, 8'h03);
      wr(`CBT_OFF_CTRL, 8'h00);
      ph1 = seg_tab[i][5:3] + 1;
      ph2 = seg_tab[i][7] ? 4 : (ph1 > `CBT_IPT_TQ ? ph1 : `CBT_IPT_TQ);
      bitq = 1 + (seg_tab[i][2:0] + 1) + ph1 + ph2;
      gap(1'b0, n); check("quantum clocks", n, 2 * (i + 1));
      gap(1'b1, n);
      gap(1'b1, n); check("bit clocks", n, bitq * 2 * (i + 1));
      rd(`CBT_OFF_STAT); check("phase2 quanta", rd_q[11:8], ph2);
    end
    wr(`CBT_OFF_SEG_A, 8'hFF); check("refused resp", bresp_q, `CBT_RESP_OKAY);
    rd(`CBT_OFF_SEG_A); check("refused write", rd_q, 32'h00000041);
    // The settings struct must carry the last accepted fields, untouched by the refused write.
    check("config fan-out", {12'h000, bt_cfg}, {12'h000, 6'h02, 8'h41, 1'b0, 3'h3});
    // Triple sampling is on: a long dominant stretch must be sampled dominant, then recessive.
    fork
      bus_u.dominant(80);
    join_none
    // The sampled bit is read on the falling edge, away from the edge that may update it.
    repeat (70) @(posedge clk_sys);
    @(negedge clk_sys);
    check("triple sample dominant", sampled_bit, 1'b0);
    repeat (100) @(posedge clk_sys);
    @(negedge clk_sys);
    check("triple sample recessive", sampled_bit, 1'b1);
    @(posedge clk_sys);
    // Filter on: a short glitch wakes nothing, a long dominant stretch wakes once.
    wr(`CBT_OFF_CTRL, 8'h01); wr(`CBT_OFF_P2W, 8'h40); wr(`CBT_OFF_CTRL, 8'h00);
    wake_n = 0;
    bus_u.dominant(4); repeat (40) @(posedge clk_sys);
    check("filtered glitch wake", wake_n, 0);
    bus_u.dominant(30); repeat (40) @(posedge clk_sys);
    check("filtered long wake", wake_n, 1);
    // Filter off: the same short glitch now wakes.
    wr(`CBT_OFF_CTRL, 8'h01); wr(`CBT_OFF_P2W, 8'h00); wr(`CBT_OFF_CTRL, 8'h00);
    wake_n = 0;
    bus_u.dominant(4); repeat (40) @(posedge clk_sys);
    check("unfiltered glitch wake", wake_n, 1);
    summarize();
  end
endmodule
